// ==== tag_regs_map.vh ====
`ifndef TAG_REGS_MAP_VH
`define TAG_REGS_MAP_VH

// ************************************************************
// Register addresses (6-bit serial register space)
// ************************************************************
`define ADDR_PIN_PULLDOWN_CONFIG   6'h00
`define ADDR_PROTOCOL_MODE_CONFIG  6'h01
`define ADDR_LINK_RATE_CONFIG      6'h02
`define ADDR_TAG_STATE_DISPLAY     6'h04
`define ADDR_FRAME_PARAM_DISPLAY   6'h05

// ************************************************************
// Serial command byte layout
// ************************************************************
`define CMD_KIND_HI                7
`define CMD_KIND_LO                6
`define CMD_KIND_WRITE             2'h0
`define CMD_KIND_READ              2'h1
`define CMD_KIND_DIRECT            2'h3
`define CMD_SET_DEFAULT_A          8'hc2
`define CMD_SET_DEFAULT_B          8'hc3

// ************************************************************
// Field positions
// ************************************************************
`define PD_SELECTED_BIT            7
`define PD_IDLE_BIT                6
`define PD_USED_MASK               8'hc0
`define MODE_HI                    5
`define MODE_LO                    4
`define RX_NO_CRC_BIT              3
`define RX_BITSTREAM_BIT           2
`define TX_NO_CRC_BIT              1
`define TX_BITSTREAM_BIT           0
`define NV_MODE_HI                 12
`define NV_MODE_LO                 7

// ************************************************************
// Mode and rate encodings, reset values
// ************************************************************
`define MODE_TRANSPORT             2'h0
`define MODE_ANTICOLL              2'h1
`define MODE_FRAMING               2'h2
`define MODE_TRANSPARENT           2'h3
`define RATE_DIV128                4'h0
`define RATE_DIV64                 4'h1
`define RATE_DIV32                 4'h2
`define RATE_DIV16                 4'h3
`define LINK_RATE_RESET            8'h00
`define FRAME_PARAM_RESET          8'h00

`endif

// ==== tag_config_status_registers.v ====
// Functional notes
// [R1] Select low, bit7 set, not driving: pull data-out line down.
// [R2] Select high, bit6 set: pull data-out line down.
// [R3] Pull-down register has no reset value; unknown until written.
// [R4] Mode bits 5:4: transport, anticollision, framing, transparent.
// [R5] Protocol mode written by register forces protocol logic to transport; code forces only on transport or anticollision writes.
// [R6] Receive no-CRC bit: skip CRC check, keep CRC bytes in FIFO.
// [R7] Receive bit-stream bit: raw bits to FIFO, no parity or CRC.
// [R8] Transmit no-CRC bit: no CRC generated on sent frames.
// [R9] Transmit bit-stream bit: send FIFO bits raw, no parity or CRC.
// [R10] At power-up the six low mode bits load from config bits 12:7.
// [R11] Rate register: tx code 7:4, rx code 3:0, zero on defaults.
// [R12] In transport mode a parameter selection overwrites the rate register.
// [R13] Codes 0..3 give carrier/128, /64, /32, /16; others reserved.
// [R14] A reserved rate code disables that transmit or receive path.
// [R15] Status bit 7 reads the field power-on signal.
// [R16] Status bits 6:4 mirror the tag state machine directly.
// [R17] Controller must not trust status reads taken during reception.
// [R18] Frame register bits 7:4 hold the reader's frame size index.
// [R19] Frame register bits 3:0 hold the assigned card identifier.
// [R20] Frame register zero on defaults, updated only in transport mode.
// [R21] Restore-defaults command C2 or C3 acts as power-up initialization.
// [R22] Config registers read and write, display registers read only.
// [R23] Reserved bits ignore writes and read as zero.
`timescale 1ns/100ps
`default_nettype none
`include "tag_regs_map.vh"

module tag_config_status_registers (
  input  wire       clk_sys,
  input  wire       srst,
  input  wire       clk_en,
  input  wire       spi_ss_n,
  input  wire       spi_sck,
  input  wire       spi_mosi,
  output reg        spi_miso_out,
  output reg        spi_miso_oe_n,
  output reg        dout_pulldown_on,
  input  wire       field_power_on,
  input  wire [2:0] tag_state,
  input  wire [15:0] nv_config_word,
  input  wire       pps_valid,
  input  wire [3:0] pps_tx_code,
  input  wire [3:0] pps_rx_code,
  input  wire       rats_valid,
  input  wire [3:0] rats_fsdi,
  input  wire [3:0] rats_cid,
  output reg  [1:0] proto_mode,
  output reg        force_transport,
  output reg        rx_no_crc,
  output reg        rx_bitstream,
  output reg        tx_no_crc,
  output reg        tx_bitstream,
  output reg  [3:0] tx_speed_code,
  output reg  [3:0] rx_speed_code,
  output reg  [7:0] tx_clk_div,
  output reg  [7:0] rx_clk_div,
  output reg        tx_enable,
  output reg        rx_enable
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Carrier divider for a rate code, zero when reserved
  function [7:0] rate_div;
    input [3:0] code;
    begin
      case (code)
        `RATE_DIV128: rate_div = 8'h80;
        `RATE_DIV64:  rate_div = 8'h40;
        `RATE_DIV32:  rate_div = 8'h20;
        `RATE_DIV16:  rate_div = 8'h10;
        default:      rate_div = 8'h00;
      endcase
    end
  endfunction

  // ************************************************************
  // Register storage
  // ************************************************************
  reg [7:0] pin_pulldown_config_reg;
  reg [5:0] protocol_mode_config_reg;
  reg [7:0] link_rate_config_reg;
  reg [7:0] frame_param_display_reg;
  reg       init_pending_reg;

  wire dout_pulldown_selected = pin_pulldown_config_reg[`PD_SELECTED_BIT];
  wire dout_pulldown_idle     = pin_pulldown_config_reg[`PD_IDLE_BIT];

  // ************************************************************
  // Pin synchronisers: three stages, stage two and three must agree
  // ************************************************************
  reg [2:0] pin_s1_reg;
  reg [2:0] pin_s2_reg;
  reg [2:0] pin_s3_reg;
  reg [2:0] pin_f_reg;
  wire [2:0] pin_raw = {spi_mosi, spi_sck, spi_ss_n};

  // Glitch filter trades one cycle of latency for immunity to slow edges
  always @(posedge clk_sys) begin
    if (srst) begin
      pin_s1_reg <= 3'h1;
      pin_s2_reg <= 3'h1;
      pin_s3_reg <= 3'h1;
      pin_f_reg  <= 3'h1;
    end else if (clk_en) begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_f_reg  <= (pin_s2_reg & (pin_s2_reg ~^ pin_s3_reg)) |
                    (pin_f_reg & (pin_s2_reg ^ pin_s3_reg));
    end
  end

  wire ss_f    = pin_f_reg[0];
  wire sck_f   = pin_f_reg[1];
  wire mosi_f  = pin_f_reg[2];
  wire agree_ss  = (pin_s2_reg[0] == pin_s3_reg[0]);
  wire agree_sck = (pin_s2_reg[1] == pin_s3_reg[1]);
  wire ss_fall   = agree_ss & ss_f & ~pin_s3_reg[0];
  wire sck_rise  = agree_sck & ~sck_f & pin_s3_reg[1] & ~ss_f;
  wire sck_fall  = agree_sck & sck_f & ~pin_s3_reg[1] & ~ss_f;

  // ************************************************************
  // Serial frame engine
  // ************************************************************
  reg [2:0] bit_cnt_reg;
  reg       first_byte_reg;
  reg [1:0] kind_reg;
  reg [5:0] addr_reg;
  reg [6:0] rx_shift_reg;
  reg [7:0] tx_shift_reg;
  reg       driving_reg;
  reg [7:0] read_data;

  wire [7:0] rx_byte   = {rx_shift_reg, mosi_f};
  wire       byte_done = sck_fall & (bit_cnt_reg == 3'h7);
  wire       cmd_done  = byte_done & first_byte_reg;
  // Later bytes of a read frame fetch the next register in line
  wire [5:0] rd_addr   = first_byte_reg ? rx_byte[5:0] :
                         (addr_reg + 6'h01);
  wire       start_read = byte_done &
               (first_byte_reg ? (rx_byte[`CMD_KIND_HI:`CMD_KIND_LO] ==
                                  `CMD_KIND_READ)
                               : (kind_reg == `CMD_KIND_READ));
  wire       reg_write = byte_done & ~first_byte_reg &
                         (kind_reg == `CMD_KIND_WRITE);
  wire       set_default = cmd_done &
                           ((rx_byte == `CMD_SET_DEFAULT_A) |
                            (rx_byte == `CMD_SET_DEFAULT_B));
  wire [7:0] wdata = rx_byte;

  // Read multiplexer; unmapped addresses and reserved bits read zero
  always @* begin
    read_data = 8'h00;
    case (rd_addr)
      `ADDR_PIN_PULLDOWN_CONFIG:
        read_data = pin_pulldown_config_reg & `PD_USED_MASK; // see [R23]
      `ADDR_PROTOCOL_MODE_CONFIG:
        read_data = {2'h0, protocol_mode_config_reg};        // see [R22]
      `ADDR_LINK_RATE_CONFIG:
        read_data = link_rate_config_reg;
      `ADDR_TAG_STATE_DISPLAY:
        // Live view, may be caught mid-change during reception; see [R17]
        read_data = {field_power_on, tag_state, 4'h0}; // see [R15] [R16]
      `ADDR_FRAME_PARAM_DISPLAY:
        read_data = frame_param_display_reg;                 // see [R18]
      default:
        read_data = 8'h00;
    endcase
  end

  // Bits are taken on falling clock, shifted out on rising clock
  always @(posedge clk_sys) begin
    if (srst) begin
      bit_cnt_reg    <= 3'h0;
      first_byte_reg <= 1'b1;
      kind_reg       <= 2'h0;
      addr_reg       <= 6'h00;
      rx_shift_reg   <= 7'h00;
      tx_shift_reg   <= 8'h00;
      driving_reg    <= 1'b0;
      spi_miso_out   <= 1'b0;
    end else if (clk_en) begin
      if (ss_fall | ss_f) begin
        bit_cnt_reg    <= 3'h0;
        first_byte_reg <= 1'b1;
        driving_reg    <= 1'b0;
      end else begin
        if (sck_fall) begin
          bit_cnt_reg  <= bit_cnt_reg + 3'h1;
          rx_shift_reg <= rx_byte[6:0];
        end
        if (byte_done) begin
          first_byte_reg <= 1'b0;
          if (first_byte_reg) begin
            kind_reg <= rx_byte[`CMD_KIND_HI:`CMD_KIND_LO];
            addr_reg <= rx_byte[5:0];
          end
          if (start_read) begin
            tx_shift_reg <= read_data;
            driving_reg  <= 1'b1;
          end
          // Address steps on so that one frame may cover several registers
          if (~first_byte_reg) begin
            addr_reg <= addr_reg + 6'h01;
          end
          if (~first_byte_reg & (kind_reg != `CMD_KIND_READ)) begin
            driving_reg <= 1'b0;
          end
        end
        if (sck_rise & driving_reg) begin
          spi_miso_out <= tx_shift_reg[7];
          tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        end
      end
    end
  end

  // ************************************************************
  // Configuration registers and the frame parameter display register
  // ************************************************************

  // No reset: this register lives on the host-side supply; see [R3]
  always @(posedge clk_sys) begin
    if (clk_en & reg_write & (addr_reg == `ADDR_PIN_PULLDOWN_CONFIG)) begin
      pin_pulldown_config_reg <= wdata & `PD_USED_MASK;      // see [R23]
    end
  end

  // Mode register: loaded from the nonvolatile word at init
  always @(posedge clk_sys) begin
    if (srst) begin
      init_pending_reg         <= 1'b1;
      protocol_mode_config_reg <= 6'h00;
      force_transport          <= 1'b0;
    end else if (clk_en) begin
      init_pending_reg <= 1'b0;
      force_transport  <= 1'b0;
      if (init_pending_reg | set_default) begin              // see [R21]
        protocol_mode_config_reg <=
          nv_config_word[`NV_MODE_HI:`NV_MODE_LO];           // see [R10]
      end else if (reg_write &
                   (addr_reg == `ADDR_PROTOCOL_MODE_CONFIG)) begin
        protocol_mode_config_reg <= wdata[5:0];              // see [R23]
        // Only a transport or anticollision mode write forces transport level
        force_transport <= (wdata[`MODE_HI:`MODE_LO] ==
                            `MODE_TRANSPORT) |
                           (wdata[`MODE_HI:`MODE_LO] ==
                            `MODE_ANTICOLL);                 // see [R5]
      end
    end
  end

  wire in_transport = (protocol_mode_config_reg[`MODE_HI:`MODE_LO] ==
                       `MODE_TRANSPORT);

  // Rate register: reader's parameter selection beats a host write
  always @(posedge clk_sys) begin
    if (srst) begin
      link_rate_config_reg <= `LINK_RATE_RESET;              // see [R11]
    end else if (clk_en) begin
      if (init_pending_reg | set_default) begin
        link_rate_config_reg <= `LINK_RATE_RESET;            // see [R21]
      end else if (pps_valid & in_transport) begin
        link_rate_config_reg <= {pps_tx_code, pps_rx_code};  // see [R12]
      end else if (reg_write & (addr_reg == `ADDR_LINK_RATE_CONFIG)) begin
        link_rate_config_reg <= wdata;                       // see [R22]
      end
    end
  end

  // Frame parameters: written only by the tag logic, never by the host
  always @(posedge clk_sys) begin
    if (srst) begin
      frame_param_display_reg <= `FRAME_PARAM_RESET;
    end else if (clk_en) begin
      if (init_pending_reg | set_default) begin
        frame_param_display_reg <= `FRAME_PARAM_RESET;       // see [R20]
      end else if (rats_valid & in_transport) begin
        frame_param_display_reg <= {rats_fsdi, rats_cid};    // see [R19]
      end
    end
  end

  // ************************************************************
  // Outputs to the framing logic and the pin driver
  // ************************************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      proto_mode       <= `MODE_TRANSPORT;
      rx_no_crc        <= 1'b0;
      rx_bitstream     <= 1'b0;
      tx_no_crc        <= 1'b0;
      tx_bitstream     <= 1'b0;
      tx_speed_code    <= 4'h0;
      rx_speed_code    <= 4'h0;
      tx_clk_div       <= 8'h80;
      rx_clk_div       <= 8'h80;
      tx_enable        <= 1'b0;
      rx_enable        <= 1'b0;
      spi_miso_oe_n    <= 1'b1;
      dout_pulldown_on <= 1'b0;
    end else if (clk_en) begin
      proto_mode    <= protocol_mode_config_reg[`MODE_HI:`MODE_LO]; // see [R4]
      rx_no_crc     <= protocol_mode_config_reg[`RX_NO_CRC_BIT];    // see [R6]
      rx_bitstream  <= protocol_mode_config_reg[`RX_BITSTREAM_BIT]; // see [R7]
      tx_no_crc     <= protocol_mode_config_reg[`TX_NO_CRC_BIT];    // see [R8]
      tx_bitstream  <= protocol_mode_config_reg[`TX_BITSTREAM_BIT]; // see [R9]
      tx_speed_code <= link_rate_config_reg[7:4];
      rx_speed_code <= link_rate_config_reg[3:0];
      tx_clk_div    <= rate_div(link_rate_config_reg[7:4]);   // see [R13]
      rx_clk_div    <= rate_div(link_rate_config_reg[3:0]);
      tx_enable     <= (rate_div(link_rate_config_reg[7:4]) !=
                        8'h00);                              // see [R14]
      rx_enable     <= (rate_div(link_rate_config_reg[3:0]) != 8'h00);
      spi_miso_oe_n <= ~(driving_reg & ~ss_f);
      // Pull-down only where nobody drives; unknown bits give unknown pull
      if (ss_f) begin
        dout_pulldown_on <= dout_pulldown_idle;              // see [R2]
      end else begin
        dout_pulldown_on <= dout_pulldown_selected &
                            ~driving_reg;                    // see [R1]
      end
    end
  end

endmodule // tag_config_status_registers
`default_nettype wire

// ==== dummy_never.v ====
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ==== tag_regs_checker_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Port checker of the register block
// ****************************************
module tag_regs_checker (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       clk_en,
  input wire logic       spi_ss_n,
  input wire logic       spi_miso_oe_n,
  input wire logic       dout_pulldown_on,
  input wire logic       pps_valid,
  input wire logic [3:0] pps_tx_code,
  input wire logic [3:0] pps_rx_code,
  input wire logic [1:0] proto_mode,
  input wire logic       force_transport,
  input wire logic [3:0] tx_speed_code,
  input wire logic [3:0] rx_speed_code,
  input wire logic [7:0] tx_clk_div,
  input wire logic [7:0] rx_clk_div,
  input wire logic       tx_enable,
  input wire logic       rx_enable
);
  logic [1:0] up_reg;
  // Outputs lag two edges after reset, so wait that gap out
  always @(posedge clk_sys) begin
    if (srst) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  reset_vals_a: assert property ($fell(srst) |-> spi_miso_oe_n
    && !dout_pulldown_on && !force_transport && !tx_enable
    && tx_clk_div == 8'h80) else $error("reset output values wrong");
  tx_div_a: assert property (up_reg == 2'h3 |-> tx_clk_div ==
    ((tx_speed_code < 4'h4) ? (8'h80 >> tx_speed_code) : 8'h00))
    else $error("tx divider does not match code");
  rx_div_a: assert property (up_reg == 2'h3 |-> rx_clk_div ==
    ((rx_speed_code < 4'h4) ? (8'h80 >> rx_speed_code) : 8'h00))
    else $error("rx divider does not match code");
  tx_gate_a: assert property (up_reg == 2'h3 |->
    tx_enable == (tx_speed_code < 4'h4)) else $error("tx enable wrong");
  rx_gate_a: assert property (up_reg == 2'h3 |->
    rx_enable == (rx_speed_code < 4'h4)) else $error("rx enable wrong");
  drive_pd_a: assert property (
    !spi_miso_oe_n |-> !dout_pulldown_on)
    else $error("pull-down while driving");
  idle_release_a: assert property (
    spi_ss_n [*8] |=> spi_miso_oe_n)
    else $error("data-out driven while deselected");
  pulse_width_a: assert property (
    force_transport && clk_en |=> !force_transport)
    else $error("force pulse too long");
  pulse_mode_a: assert property (force_transport |-> ##[0:3]
    !proto_mode[1]) else $error("force pulse outside protocol mode");
  // A frozen block may skip the selection, so both edges need the enable
  pps_take_a: assert property (
    pps_valid && clk_en && proto_mode == 2'h0 ##1 clk_en
    |=> tx_speed_code == $past(pps_tx_code, 2)
    && rx_speed_code == $past(pps_rx_code, 2)) else $error("rate not taken");
endmodule // tag_regs_checker
bind tag_config_status_registers tag_regs_checker chk (
  .clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .spi_ss_n(spi_ss_n),
  .spi_miso_oe_n(spi_miso_oe_n), .dout_pulldown_on(dout_pulldown_on),
  .pps_valid(pps_valid), .pps_tx_code(pps_tx_code),
  .pps_rx_code(pps_rx_code), .proto_mode(proto_mode),
  .force_transport(force_transport), .tx_speed_code(tx_speed_code),
  .rx_speed_code(rx_speed_code), .tx_clk_div(tx_clk_div),
  .rx_clk_div(rx_clk_div), .tx_enable(tx_enable), .rx_enable(rx_enable));
`default_nettype wire

// ==== spi_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Serial master on the controller side
// ****************************************
module spi_host_model (
  output var logic spi_ss_n,
  output var logic spi_sck,
  output var logic spi_mosi,
  input wire logic spi_miso_out,
  input wire logic spi_miso_oe_n,
  input wire logic dout_pulldown_on
);
  logic float_reg = 1'b0;
  logic line;
  // Undriven, unpulled line wanders so a stale bit never reads right
  always @(posedge spi_sck) float_reg <= ~float_reg;
  assign line = !spi_miso_oe_n ? spi_miso_out :
                (dout_pulldown_on ? 1'b0 : float_reg);
  initial begin
    spi_ss_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
  end
  // Select change with settling time either side
  task sel(input logic lvl);
    #100 spi_ss_n = lvl;
    #100;
  endtask
  // One byte MSB first; sample late since data lags the rising edge
  task xbyte(input logic [7:0] d, output logic [7:0] q);
    integer k;
    for (k = 7; k >= 0; k = k - 1) begin
      spi_mosi = d[k];
      #20 spi_sck = 1'b1;
      #100 spi_sck = 1'b0;
      #80 q = {q[6:0], line};
    end
  endtask
endmodule // spi_host_model
`default_nettype wire

// ==== tag_config_status_registers_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked = checked + 1; if ((a) !== (e)) begin \
  n_fail = n_fail + 1; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
// ****************************************
// Register block bench
// ****************************************
module tag_config_status_registers_tb;
  logic [15:0] nv_word = 16'h1a80;
  logic       clk_sys = 1'b0;
  logic       clk_en = 1'b1;
  logic       srst = 1'b1;
  logic       field_power_on = 1'b0;
  logic [2:0] tag_state = 3'h0;
  logic       pv = 1'b0;
  logic [3:0] pa = 4'h0;
  logic [3:0] pb = 4'h0;
  logic [7:0] q, e;
  wire        ss_n, sck, mosi, mo, oe_n, pd, ft, rnc, rbs, tnc, tbs, te, re;
  wire  [1:0] pm;
  wire  [3:0] tc, rc;
  wire  [7:0] td, rd_div;
  integer     n_fail = 0, checked = 0, n_force = 0, i, j;
  always #12.5 clk_sys = ~clk_sys;
  tag_config_status_registers dut (.clk_sys(clk_sys), .srst(srst),
    .clk_en(clk_en), .spi_ss_n(ss_n), .spi_sck(sck), .spi_mosi(mosi),
    .spi_miso_out(mo), .spi_miso_oe_n(oe_n), .dout_pulldown_on(pd),
    .field_power_on(field_power_on), .tag_state(tag_state),
    .nv_config_word(nv_word), .pps_valid(pv), .pps_tx_code(pa),
    .pps_rx_code(pb), .rats_valid(pv), .rats_fsdi(pa), .rats_cid(pb),
    .proto_mode(pm), .force_transport(ft), .rx_no_crc(rnc),
    .rx_bitstream(rbs), .tx_no_crc(tnc), .tx_bitstream(tbs),
    .tx_speed_code(tc), .rx_speed_code(rc), .tx_clk_div(td),
    .rx_clk_div(rd_div), .tx_enable(te), .rx_enable(re));
  spi_host_model host (.spi_ss_n(ss_n), .spi_sck(sck), .spi_mosi(mosi),
    .spi_miso_out(mo), .spi_miso_oe_n(oe_n), .dout_pulldown_on(pd));
  // Count force pulses to see which mode writes raise one
  always @(posedge clk_sys) if (ft === 1'b1) n_force <= n_force + 1;
  function logic [7:0] dv(input logic [3:0] c);
    dv = (c < 4'h4) ? (8'h80 >> c) : 8'h00;
  endfunction
  task wr(input logic [5:0] a, input logic [7:0] d);
    host.sel(1'b0);
    host.xbyte({2'h0, a}, q);
    host.xbyte(d, q);
    host.sel(1'b1);
    repeat (4) @(negedge clk_sys);
  endtask
  task rd(input logic [5:0] a, output logic [7:0] d);
    host.sel(1'b0);
    host.xbyte({2'h1, a}, q);
    host.xbyte(8'h00, d);
    host.sel(1'b1);
  endtask
  // Parameter selection and frame-size update from the reader side
  task pulse(input logic [3:0] a, input logic [3:0] b);
    @(negedge clk_sys) {pv, pa, pb} = {1'b1, a, b};
    @(negedge clk_sys) pv = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  // Check the pull-down level while idle and while merely selected
  task pdn(input logic [7:0] d, input logic idle_lvl);
    wr(6'h00, d);
    `CHK(pd, idle_lvl)
    host.sel(1'b0);
    repeat (10) @(negedge clk_sys);
    `CHK(pd, ~idle_lvl)
    host.sel(1'b1);
  endtask
  task conclude;
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail = n_fail + 1;
    conclude;
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
    repeat (8) @(negedge clk_sys);
    pdn(8'h7f, 1'b1);
    pdn(8'hbf, 1'b0);
    rd(6'h00, q); `CHK(q, 8'h80)
    rd(6'h01, q); `CHK(q, ({2'h0, nv_word[12:7]}))
    `CHK(pm, nv_word[12:11])
    rd(6'h02, q); `CHK(q, 8'h00)
    rd(6'h05, q); `CHK(q, 8'h00)
    // Every mode, each option flag both ways, reserved bits set
    for (i = 0; i < 4; i = i + 1) begin
      e = {2'h0, i[1:0], 4'hf ^ (4'h1 << i)};
      j = n_force;
      wr(6'h01, e | 8'hc0);
      rd(6'h01, q); `CHK(q, e)
      `CHK(({pm, rnc, rbs, tnc, tbs}), e[5:0])
      `CHK(n_force - j, (i < 2) ? 1 : 0)
    end
    // Supported rate codes and one reserved code on each path
    for (i = 0; i < 5; i = i + 1) begin
      e = {i[3:0], 4'h4 - i[3:0]};
      wr(6'h02, e);
      rd(6'h02, q); `CHK(q, e)
      `CHK(({td, rd_div}), ({dv(e[7:4]), dv(e[3:0])}))
      `CHK(({te, re}), ({e[7:4] < 4'h4, e[3:0] < 4'h4}))
    end
    pulse(4'h3, 4'h2);
    rd(6'h02, q); `CHK(q, 8'h40)
    rd(6'h05, q); `CHK(q, 8'h00)
    wr(6'h01, 8'h00);
    // A frozen block must miss a selection that comes while halted
    @(negedge clk_sys) clk_en = 1'b0;
    pulse(4'h1, 4'h1);
    clk_en = 1'b1;
    rd(6'h02, q); `CHK(q, 8'h40)
    rd(6'h05, q); `CHK(q, 8'h00)
    pulse(4'h3, 4'h2);
    rd(6'h02, q); `CHK(q, 8'h32)
    rd(6'h05, q); `CHK(q, 8'h32)
    // Status reads taken with no reception under way
    for (i = 0; i < 8; i = i + 1) begin
      @(negedge clk_sys) {field_power_on, tag_state} = {~i[0], i[2:0]};
      rd(6'h04, q); `CHK(q, ({~i[0], i[2:0], 4'h0}))
    end
    wr(6'h04, 8'hff);
    wr(6'h3f, 8'hff);
    rd(6'h04, q); `CHK(q, 8'h70)
    rd(6'h02, q); `CHK(q, 8'h32)
    // Both restore codes after dirtying the rate and frame registers, two config words
    for (i = 0; i < 2; i = i + 1) begin
      wr(6'h02, 8'h13);
      pulse(4'h5, 4'h6);
      nv_word = i[0] ? 16'h0500 : 16'h1a80;
      host.sel(1'b0);
      host.xbyte(8'hc2 | i[7:0], q);
      host.sel(1'b1);
      repeat (4) @(negedge clk_sys);
      rd(6'h01, q); `CHK(q, ({2'h0, nv_word[12:7]}))
      `CHK(pm, nv_word[12:11])
      rd(6'h02, q); `CHK(q, 8'h00)
      rd(6'h05, q); `CHK(q, 8'h00)
      wr(6'h01, 8'h00);
    end
    // Mid-run reset reloads the mode word and clears the rate register
    nv_word = 16'h0f80;
    wr(6'h02, 8'h21);
    srst = 1'b1;
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
    repeat (8) @(negedge clk_sys);
    `CHK(({pm, rnc, rbs, tnc, tbs}), nv_word[12:7])
    `CHK(({te, re, td, rd_div}), ({2'h3, 16'h8080}))
    rd(6'h02, q); `CHK(q, 8'h00)
    conclude;
  end
endmodule // tag_config_status_registers_tb
`default_nettype wire
